// [shared/liu_port_consts.svh]
// register offsets, field positions, reset values and rate counts of the system-side data port
`ifndef LIU_PORT_CONSTS_SVH
`define LIU_PORT_CONSTS_SVH

`define AXI_ADDR_W 4
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_LOL_COUNT 4'h8

`define CTRL_RESET 32'h0000_0011
`define CTRL_MASK 32'h0000_003F
`define CTRL_COAX_BIT 0
`define CTRL_TXINV_BIT 1
`define CTRL_MODE_LSB 2
`define CTRL_TXEN_BIT 4
`define CTRL_CORE_RST_BIT 5

`define STAT_LOST_BIT 0
`define STAT_LOL_BIT 1
`define STAT_CORE_RST_BIT 2

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define TX_HALF_DIV 8'h04
`define RX_HOLD_HALF_DIV 8'h04

`define NIBBLE_LAST 2'h3
`define PAR_CLK_RISE_CNT 2'h1
`define TX_CAPTURE_CNT 2'h1

`define LOL_PPM 32'h0000_0064
`define PPM_SCALE 32'h000F_4240
`define LOL_WINDOW_DFLT 32'h0000_4E20

`endif

// [shared/liu_port_pkg.sv]
// types shared by the system-side data port
package liu_port_pkg;
  typedef enum logic [1:0] {
    TX_MASTER_PAR = 2'b00,
    TX_SLAVE_PAR = 2'b01,
    TX_SERIAL = 2'b10,
    TX_LOOP_PAR = 2'b11
  } tx_mode_e;
  typedef logic [3:0] nibble_t;
endpackage : liu_port_pkg

// [hw/sync_2ff.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule : sync_2ff

// [hw/half_tick_gen.sv]
// divider that pulses once every i_half_div clocks while running
`timescale 1ns/10ps
module half_tick_gen (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_run,
  input wire logic [7:0] i_half_div,
  output logic o_tick
);
  logic [7:0] count;
  wire at_end = (count <= 8'h01);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= 8'h01;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      count <= i_half_div;
      o_tick <= 1'b0;
    end else if (at_end) begin
      count <= i_half_div;
      o_tick <= 1'b1;
    end else begin
      count <= count - 8'h01;
      o_tick <= 1'b0;
    end
  end
endmodule : half_tick_gen

// [hw/liu_system_side_data_port.sv]
// system-side data port of one line interface channel with its register slave
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "liu_port_consts.svh"
module liu_system_side_data_port import liu_port_pkg::*; #(
  parameter int LOL_WINDOW = `LOL_WINDOW_DFLT
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [3:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [3:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic [3:0] i_tx_nibble,
  input wire logic i_tx_par_clk_in,
  output logic o_tx_par_clk_out,
  output logic o_tx_par_clk_oe,
  input wire logic i_tx_serial_data_p,
  input wire logic i_tx_serial_clk_p,
  output logic o_coax_line_out_p,
  output logic o_coax_line_out_n,
  output logic o_coax_line_oe,
  output logic o_tx_line_clk_out_p,
  output logic o_tx_line_clk_out_n,
  output logic o_fibre_data_out_p,
  output logic o_fibre_data_out_n,
  input wire logic i_line_in_p,
  input wire logic i_rx_rec_clk,
  input wire logic i_signal_lost,
  input wire logic i_ref_clk_p,
  output logic [3:0] o_rx_nibble,
  output logic o_rx_par_clk_out,
  output logic o_rx_serial_data_p,
  output logic o_rx_serial_data_n,
  output logic o_rx_serial_clk_p,
  output logic o_rx_serial_clk_n,
  output logic o_rx_loss_of_lock
);
  localparam int unsigned LOL_TOL = LOL_WINDOW * `LOL_PPM / `PPM_SCALE;

  // ---- register slave ----
  logic [31:0] ctrl;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [15:0] lol_count;
  logic lol_flag;
  logic lost_s;

  wire aw_take = i_awvalid & o_awready;
  wire w_take = i_wvalid & o_wready;
  wire aw_have = ~o_awready;
  wire w_have = ~o_wready;
  wire wr_ready = aw_have & w_have & ~o_bvalid;
  wire wr_ctrl = wr_ready & (aw_addr == `REG_CTRL) & w_strb[0];
  wire wr_known = (aw_addr == `REG_CTRL) | (aw_addr == `REG_STATUS) |
                  (aw_addr == `REG_LOL_COUNT);
  wire ar_take = i_arvalid & o_arready;
  wire [31:0] status_word = {29'h0, ctrl[`CTRL_CORE_RST_BIT], lol_flag, lost_s};

  function automatic logic [32:0] read_word(input logic [3:0] addr, input logic [31:0] c,
                                            input logic [31:0] s, input logic [15:0] n);
    logic [32:0] r;
    r = {1'b1, 32'h0};
    unique case (addr)
      `REG_CTRL: r = {1'b0, c};
      `REG_STATUS: r = {1'b0, s};
      `REG_LOL_COUNT: r = {1'b0, 16'h0, n};
      default: r = {1'b1, 32'h0};
    endcase
    return r;
  endfunction : read_word

  wire [32:0] rd_sel = read_word(i_araddr, ctrl, status_word, lol_count);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= `RESP_OKAY;
    end else begin
      if (aw_take) begin
        o_awready <= 1'b0;
        aw_addr <= i_awaddr;
      end
      if (w_take) begin
        o_wready <= 1'b0;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (wr_ready) begin
        o_bvalid <= 1'b1;
        o_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (o_bvalid & i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= {24'h0, w_data[7:0]} & `CTRL_MASK;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= `RESP_OKAY;
    end else if (ar_take) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_sel[31:0];
      o_rresp <= rd_sel[32] ? `RESP_SLVERR : `RESP_OKAY;
    end else if (o_rvalid & i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // ---- control fields ----
  wire coax_line_select = ctrl[`CTRL_COAX_BIT];
  wire tx_clk_invert = ctrl[`CTRL_TXINV_BIT];
  wire tx_enable = ctrl[`CTRL_TXEN_BIT];
  wire core_rst = ctrl[`CTRL_CORE_RST_BIT];
  tx_mode_e tx_mode;
  assign tx_mode = tx_mode_e'(ctrl[`CTRL_MODE_LSB +: 2]);
  wire master_mode = (tx_mode == TX_MASTER_PAR);
  wire serial_mode = (tx_mode == TX_SERIAL);

  // ---- pin synchronisers ----
  logic [10:0] pins_s;
  logic par_clk_q, ser_clk_q, rec_clk_q, ref_q;

  sync_2ff #(.WIDTH(11)) u_pin_sync (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_async({i_tx_nibble, i_tx_par_clk_in, i_tx_serial_clk_p, i_tx_serial_data_p,
              i_line_in_p, i_rx_rec_clk, i_signal_lost, i_ref_clk_p}),
    .o_sync(pins_s)
  );

  wire [3:0] nibble_s = pins_s[10:7];
  wire par_clk_s = pins_s[6];
  wire ser_clk_s = pins_s[5];
  wire ser_data_s = pins_s[4];
  wire line_s = pins_s[3];
  wire rec_clk_s = pins_s[2];
  assign lost_s = pins_s[1];
  wire ref_s = pins_s[0];

  // capture edge follows the inversion bit
  wire par_edge = tx_clk_invert ? (par_clk_q & ~par_clk_s) : (~par_clk_q & par_clk_s);
  wire ser_edge = tx_clk_invert ? (ser_clk_q & ~ser_clk_s) : (~ser_clk_q & ser_clk_s);
  wire rec_rise = ~rec_clk_q & rec_clk_s;
  wire rec_fall = rec_clk_q & ~rec_clk_s;
  wire ref_rise = ~ref_q & ref_s;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      par_clk_q <= 1'b0;
      ser_clk_q <= 1'b0;
      rec_clk_q <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      par_clk_q <= par_clk_s;
      ser_clk_q <= ser_clk_s;
      rec_clk_q <= rec_clk_s;
      ref_q <= ref_s;
    end
  end

  // ---- transmit path ----
  // line timing free-runs from the bus reset so the clocks survive the core reset
  logic tx_tick, tx_half;
  logic [1:0] tx_cnt;
  nibble_t tx_hold, tx_shift, ser_acc;
  logic [1:0] ser_cnt;
  logic cmi_one_level;

  half_tick_gen u_tx_div (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_run(1'b1),
    .i_half_div(`TX_HALF_DIV),
    .o_tick(tx_tick)
  );

  wire tx_bit_edge = tx_tick & tx_half;
  wire tx_last = (tx_cnt == `NIBBLE_LAST);
  wire next_bit = tx_last ? tx_hold[3] : tx_shift[2];
  wire master_cap = master_mode & tx_bit_edge & (tx_cnt == `TX_CAPTURE_CNT);
  wire slave_cap = ~master_mode & ~serial_mode & par_edge;
  wire ser_word = serial_mode & ser_edge & (ser_cnt == `NIBBLE_LAST);
  wire line_bit = tx_half ? next_bit : tx_shift[3];
  wire next_cmi = tx_half ? (next_bit ? ~cmi_one_level : 1'b0) : (tx_shift[3] ? cmi_one_level : 1'b1);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_half <= 1'b0;
      tx_cnt <= 2'h0;
      o_tx_line_clk_out_p <= 1'b0;
      o_tx_line_clk_out_n <= 1'b1;
      o_tx_par_clk_out <= 1'b0;
    end else if (tx_tick) begin
      tx_half <= ~tx_half;
      o_tx_line_clk_out_p <= ~o_tx_line_clk_out_p;
      o_tx_line_clk_out_n <= o_tx_line_clk_out_p;
      if (tx_half) begin
        tx_cnt <= tx_cnt + 2'h1;
        o_tx_par_clk_out <= tx_last | (tx_cnt == 2'h0);
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_hold <= 4'h0;
      tx_shift <= 4'h0;
      ser_acc <= 4'h0;
      ser_cnt <= 2'h0;
    end else if (core_rst) begin
      tx_hold <= 4'h0;
      tx_shift <= 4'h0;
      ser_acc <= 4'h0;
      ser_cnt <= 2'h0;
    end else begin
      if (master_cap | slave_cap) begin
        tx_hold <= nibble_s;
      end else if (ser_word) begin
        tx_hold <= {ser_acc[2:0], ser_data_s};
      end
      if (serial_mode & ser_edge) begin
        ser_acc <= {ser_acc[2:0], ser_data_s};
        ser_cnt <= ser_cnt + 2'h1;
      end
      if (tx_bit_edge) begin
        tx_shift <= tx_last ? tx_hold : {tx_shift[2:0], 1'b0};
      end
    end
  end

  // coder keeps running in core reset, so the coax pins toggle with the CMI pattern of all-zero data
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmi_one_level <= 1'b0;
      o_coax_line_out_p <= 1'b0;
      o_coax_line_out_n <= 1'b1;
      o_coax_line_oe <= 1'b0;
      o_tx_par_clk_oe <= 1'b0;
      o_fibre_data_out_p <= 1'b0;
      o_fibre_data_out_n <= 1'b0;
    end else begin
      o_coax_line_oe <= tx_enable & coax_line_select;
      o_tx_par_clk_oe <= master_mode;
      if (tx_tick) begin
        if (tx_half & next_bit) begin
          cmi_one_level <= ~cmi_one_level;
        end
        o_coax_line_out_p <= next_cmi;
        o_coax_line_out_n <= ~next_cmi;
        o_fibre_data_out_p <= ~coax_line_select & tx_enable & line_bit;
        o_fibre_data_out_n <= ~coax_line_select & tx_enable & ~line_bit;
      end else if (coax_line_select | ~tx_enable) begin
        // quiet the fibre pair at once so it never overlaps the coax enable
        o_fibre_data_out_p <= 1'b0;
        o_fibre_data_out_n <= 1'b0;
      end
    end
  end

  // ---- receive path ----
  logic hold_tick, rx_half, cmi_first;
  logic [1:0] rx_cnt;
  nibble_t rx_shift;

  half_tick_gen u_rx_hold (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_run(lost_s),
    .i_half_div(`RX_HOLD_HALF_DIV),
    .o_tick(hold_tick)
  );

  // holdover ticks start a full count after the loss is seen while rx_half and rx_cnt carry on from their last phase, so the clocks stay steady
  wire live_half = coax_line_select ? rec_rise : (rec_rise | rec_fall);
  wire rx_tick = lost_s ? hold_tick : live_half;
  wire rx_bit_edge = rx_tick & rx_half;
  wire rx_bit = coax_line_select ? (cmi_first == line_s) : line_s;
  wire rx_last = (rx_cnt == `NIBBLE_LAST);
  wire [3:0] rx_word = {rx_shift[2:0], rx_bit};

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_half <= 1'b0;
      rx_cnt <= 2'h0;
      cmi_first <= 1'b0;
      o_rx_par_clk_out <= 1'b0;
      o_rx_serial_clk_p <= 1'b0;
      o_rx_serial_clk_n <= 1'b1;
    end else if (rx_tick) begin
      rx_half <= ~rx_half;
      o_rx_serial_clk_p <= ~rx_half;
      o_rx_serial_clk_n <= rx_half;
      if (!rx_half) begin
        cmi_first <= line_s;
      end else begin
        rx_cnt <= rx_cnt + 2'h1;
        if (rx_last) begin
          o_rx_par_clk_out <= 1'b0;
        end else if (rx_cnt == `PAR_CLK_RISE_CNT) begin
          o_rx_par_clk_out <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_shift <= 4'h0;
      o_rx_nibble <= 4'h0;
      o_rx_serial_data_p <= 1'b0;
      o_rx_serial_data_n <= 1'b1;
    end else if (lost_s) begin
      rx_shift <= 4'h0;
      o_rx_nibble <= 4'h0;
      o_rx_serial_data_p <= 1'b0;
      o_rx_serial_data_n <= 1'b1;
    end else if (rx_bit_edge) begin
      rx_shift <= core_rst ? 4'h0 : rx_word;
      o_rx_serial_data_p <= rx_bit;
      o_rx_serial_data_n <= ~rx_bit;
      if (rx_last) begin
        o_rx_nibble <= rx_word;
      end
    end
  end

  // ---- frequency lock monitor ----
  logic [15:0] ref_cnt;
  logic [16:0] rec_cnt;
  wire window_end = ref_rise & ({16'h0, ref_cnt} == LOL_WINDOW[31:0] - 32'h1);
  wire [31:0] expect_cnt = coax_line_select ? (LOL_WINDOW[31:0] << 1) : LOL_WINDOW[31:0];
  // a recovered edge on the closing reference edge belongs to this window
  wire [31:0] rec_ext = {15'h0, rec_cnt} + {31'h0, rec_rise};
  wire off_freq = (rec_ext > expect_cnt + LOL_TOL) | (rec_ext + LOL_TOL < expect_cnt);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ref_cnt <= 16'h0;
      rec_cnt <= 17'h0;
      lol_count <= 16'h0;
      lol_flag <= 1'b0;
      o_rx_loss_of_lock <= 1'b0;
    end else if (window_end) begin
      ref_cnt <= 16'h0;
      rec_cnt <= 17'h0;
      lol_count <= rec_ext[15:0];
      lol_flag <= off_freq;
      o_rx_loss_of_lock <= off_freq;
    end else begin
      if (ref_rise) begin
        ref_cnt <= ref_cnt + 16'h1;
      end
      if (rec_rise & ~&rec_cnt) begin
        rec_cnt <= rec_cnt + 17'h1;
      end
    end
  end
endmodule : liu_system_side_data_port

// [sim/liu_port_props.sv]
// concurrent checks on the data port pins and register bus
`timescale 1ns/10ps
module liu_port_props (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic o_coax_line_oe,
  input wire logic o_fibre_data_out_p,
  input wire logic o_tx_line_clk_out_p,
  input wire logic i_signal_lost,
  input wire logic [3:0] o_rx_nibble,
  input wire logic o_rx_par_clk_out,
  input wire logic o_rx_serial_data_p,
  input wire logic o_rx_serial_clk_p
);
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);
  // five samples cover the input synchroniser and the output register
  sequence lost_held;
    i_signal_lost [*5];
  endsequence
  sequence lost_clear;
    !i_signal_lost [*5];
  endsequence
  a_lost_nibble: assert property (lost_held |-> o_rx_nibble == 4'h0)
    else $error("receive nibble not low during signal loss");
  a_lost_serial: assert property (lost_held |-> !o_rx_serial_data_p)
    else $error("serial data not low during signal loss");
  a_hold_serial_clk: assert property (lost_held |-> ##[1:9] $changed(o_rx_serial_clk_p))
    else $error("serial clock stopped during signal loss");
  a_hold_par_clk: assert property (lost_held |-> ##[1:40] $changed(o_rx_par_clk_out))
    else $error("parallel clock stopped during signal loss");
  a_nibble_on_fall: assert property (
    lost_clear ##0 $changed(o_rx_nibble) |-> $fell(o_rx_par_clk_out))
    else $error("receive nibble changed off the clock fall");
  a_serial_on_fall: assert property (
    lost_clear ##0 $changed(o_rx_serial_data_p) |-> $fell(o_rx_serial_clk_p))
    else $error("serial data changed off the clock fall");
  a_line_clk_rate: assert property (
    $rose(o_tx_line_clk_out_p) |-> o_tx_line_clk_out_p [*4] ##1 !o_tx_line_clk_out_p)
    else $error("line clock half period is not four cycles");
  a_fibre_quiet: assert property (o_coax_line_oe |-> !o_fibre_data_out_p)
    else $error("fibre output active in coax mode");
  a_write_blocked: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted while response pending");
  a_read_blocked: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted while data pending");
endmodule : liu_port_props

// [sim/liu_framer_model.sv]
// framer model driving the slave parallel transmit bus
`timescale 1ns/10ps
module liu_framer_model import liu_port_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_run,
  input wire logic i_inv,
  output logic o_par_clk,
  output nibble_t o_nibble
);
  logic [4:0] phase;
  nibble_t cur;
  nibble_t sent_q[$];
  // data is good only near the capture edge, so a wrong edge sees garbage
  wire in_window = (phase[4] == phase[3]) ^ i_inv;
  assign o_par_clk = i_run & ~phase[4];
  assign o_nibble = in_window ? cur : ~cur;
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase <= 5'h00;
      cur <= 4'h0;
    end else begin
      phase <= i_run ? phase + 5'h01 : 5'h00;
      if (phase == (i_inv ? 5'h07 : 5'h17)) cur <= nibble_t'($urandom);
      if (i_run && phase == (i_inv ? 5'h0F : 5'h1F)) sent_q.push_back(cur);
    end
  end
endmodule : liu_framer_model

// [sim/test_liu_system_side_data_port.sv]
// self-checking bench for the system-side data port
`timescale 1ns/10ps
`include "liu_port_consts.svh"
module test_liu_system_side_data_port;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic run = 1'b0, inv = 1'b0, rec = 1'b0, line = 1'b0, lost = 1'b0, ref_clk = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, par_clk, par_oe, coax_oe, lclk, fib_p;
  logic rx_pclk, rx_sd;
  logic sdat = 1'b0, sclk = 1'b0, par_out, lol;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] nib, rx_nib;
  int err_total = 0;
  int check_count = 0;
  bit exp_q[$], obs_q[$];

  always #5 mclk = ~mclk;
  always @(posedge mclk) ref_clk <= ~ref_clk;

  liu_system_side_data_port #(.LOL_WINDOW(1000)) liu_system_side_data_port_inst (
    .i_mclk(mclk), .i_rst_b(rst_b), .i_awvalid(awvalid), .o_awready(awready),
    .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(4'hF), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
    .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_tx_nibble(nib),
    .i_tx_par_clk_in(par_clk), .o_tx_par_clk_out(par_out), .o_tx_par_clk_oe(par_oe),
    .i_tx_serial_data_p(sdat), .i_tx_serial_clk_p(sclk), .o_coax_line_out_p(),
    .o_coax_line_out_n(), .o_coax_line_oe(coax_oe), .o_tx_line_clk_out_p(lclk),
    .o_tx_line_clk_out_n(), .o_fibre_data_out_p(fib_p), .o_fibre_data_out_n(),
    .i_line_in_p(line), .i_rx_rec_clk(rec), .i_signal_lost(lost), .i_ref_clk_p(ref_clk),
    .o_rx_nibble(rx_nib), .o_rx_par_clk_out(rx_pclk), .o_rx_serial_data_p(rx_sd),
    .o_rx_serial_data_n(), .o_rx_serial_clk_p(), .o_rx_serial_clk_n(),
    .o_rx_loss_of_lock(lol)
  );

  liu_framer_model liu_framer_model_inst (
    .i_mclk(mclk), .i_rst_b(rst_b), .i_run(run), .i_inv(inv), .o_par_clk(par_clk),
    .o_nibble(nib)
  );

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // the nibble boundary phase is not visible, so search for the expected run
  function automatic bit found(int s, int len);
    for (int o = 0; o + len <= obs_q.size(); o++) begin
      int k;
      for (k = 0; k < len && obs_q[o + k] == exp_q[s + k]; k++);
      if (k == len) return 1'b1;
    end
    return 1'b0;
  endfunction : found

  task automatic tx_run(input logic iv, input logic ser);
    logic [1:0] r;
    inv <= iv;
    wr(`REG_CTRL, {27'h0, 1'b1, ser, ~ser, iv, 1'b0}, r);
    liu_framer_model_inst.sent_q.delete();
    obs_q.delete();
    exp_q.delete();
    run <= ~ser;
    fork
      repeat (320) begin
        @(lclk);
        repeat (2) @(posedge mclk);
        obs_q.push_back(fib_p);
      end
      if (ser) begin
        // serial source: one bit per 8 clocks, data steady around the rising edge
        repeat (160) begin
          sdat <= 1'($urandom);
          sclk <= 1'b0;
          repeat (4) @(posedge mclk);
          sclk <= 1'b1;
          repeat (2) exp_q.push_back(sdat);
          repeat (4) @(posedge mclk);
        end
      end
    join
    run <= 1'b0;
    foreach (liu_framer_model_inst.sent_q[i])
      for (int b = 3; b >= 0; b--)
        repeat (2) exp_q.push_back(liu_framer_model_inst.sent_q[i][b]);
    chk("tx fibre stream", 32'h1, {31'h0, found(16, 64)});
    $display("tx test done, invert %0d serial %0d", iv, ser);
  endtask : tx_run

  task automatic half(input logic h);
    rec <= 1'b0;
    line <= h;
    repeat (4) @(posedge mclk);
    rec <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : half

  initial begin
    logic [31:0] d, v;
    logic [1:0] r;
    logic lvl;
    int n;
    v = $urandom(32'h0609);
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    rd(`REG_CTRL, d, r);
    chk("ctrl reset", `CTRL_RESET, d);
    rd(4'hC, d, r);
    chk("unmapped read data", 32'h0, d);
    chk("unmapped read resp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    wr(4'hC, 32'hFFFF_FFFF, r);
    chk("unmapped write resp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    repeat (4) begin
      v = $urandom & 32'hFFFF_FFDF;
      wr(`REG_CTRL, v, r);
      rd(`REG_CTRL, d, r);
      chk("ctrl readback", v & `CTRL_MASK, d);
    end
    $display("register test done");
    for (int m = 0; m < 16; m++) begin
      wr(`REG_CTRL, {27'h0, m[3], m[2:1], 1'b0, m[0]}, r);
      repeat (3) @(posedge mclk);
      chk("par clk enable", {31'h0, m[2:1] == 2'h0}, {31'h0, par_oe});
      chk("coax enable", {31'h0, m[3] & m[0]}, {31'h0, coax_oe});
    end
    $display("mode test done");
    // master mode with the core reset held: the nibble clock must keep running
    wr(`REG_CTRL, 32'h0000_0031, r);
    n = 0;
    repeat (64) begin
      lvl = par_out;
      @(posedge mclk);
      n += (par_out != lvl) ? 1 : 0;
    end
    chk("par clk edges in core reset", 32'h4, n);
    $display("par clk test done");
    tx_run(1'b0, 1'b0);
    tx_run(1'b1, 1'b0);
    tx_run(1'b0, 1'b1);
    wr(`REG_CTRL, `CTRL_RESET, r);
    exp_q.delete();
    obs_q.delete();
    repeat (48) exp_q.push_back(1'($urandom));
    lvl = 1'b0;
    fork
      foreach (exp_q[i]) begin
        lvl = exp_q[i] ? ~lvl : lvl;
        half(exp_q[i] ? lvl : 1'b0);
        half(exp_q[i] ? lvl : 1'b1);
      end
      repeat (9) begin
        @(negedge rx_pclk);
        @(posedge mclk);
        for (int b = 3; b >= 0; b--) obs_q.push_back(rx_nib[b]);
      end
    join
    chk("rx nibble stream", 32'h1, {31'h0, found(8, 16)});
    $display("rx test done");
    lost <= 1'b1;
    // the recovered clock keeps running through the loss, as a real recovery loop would
    repeat (60) begin
      @(posedge mclk);
      rec <= ~rec;
    end
    chk("rx nibble in loss", 32'h0, {28'h0, rx_nib});
    chk("rx serial in loss", 32'h0, {31'h0, rx_sd});
    rd(`REG_STATUS, d, r);
    chk("status lost bit", 32'h1, {31'h0, d[`STAT_LOST_BIT]});
    lost <= 1'b0;
    repeat (20) begin
      @(posedge mclk);
      rec <= ~rec;
    end
    $display("signal loss test done");
    // fibre mode expects one recovered rise per reference rise in each window
    wr(`REG_CTRL, 32'h0000_0010, r);
    repeat (4200) begin
      @(posedge mclk);
      rec <= ~rec;
    end
    chk("loss of lock while locked", 32'h0, {31'h0, lol});
    repeat (4200) @(posedge mclk);
    chk("loss of lock with clock stopped", 32'h1, {31'h0, lol});
    rd(`REG_STATUS, d, r);
    chk("status lol bit", 32'h1, {31'h0, d[`STAT_LOL_BIT]});
    $display("lock monitor test done");
    results();
  end

  initial begin
    repeat (30000) @(posedge mclk);
    err_total++;
    $display("ERROR watchdog expected finish seen timeout");
    results();
  end
endmodule : test_liu_system_side_data_port

bind liu_system_side_data_port liu_port_props liu_port_props_inst (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .o_awready(o_awready), .o_wready(o_wready),
  .o_bvalid(o_bvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
  .o_coax_line_oe(o_coax_line_oe), .o_fibre_data_out_p(o_fibre_data_out_p),
  .o_tx_line_clk_out_p(o_tx_line_clk_out_p), .i_signal_lost(i_signal_lost),
  .o_rx_nibble(o_rx_nibble), .o_rx_par_clk_out(o_rx_par_clk_out),
  .o_rx_serial_data_p(o_rx_serial_data_p), .o_rx_serial_clk_p(o_rx_serial_clk_p)
);
